// ---- tbcap_asserts.sv ----
// tbcap_asserts: port checks of the capture unit against a small shadow of its state
// assumes: bound to tbcap_top; register index is paddr[17:2]
`timescale 1ns/1ps
module tbcap_asserts (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// time base and requests
	input wire logic        low_speed_clock,
	input wire logic [7:0]  time_base_taps,
	input wire logic        pin_irq_request_ch0,
	input wire logic        pin_irq_request_ch1,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic            lp_ff;
	logic [1:0]      en_ff, arm_ff, flg_ff, cap_ff, st_ff, msk_ff;
	logic [1:0][7:0] d_ff;
	wire        wr   = psel & penable & pready & pwrite;
	wire        rd   = psel & penable & pready & !pwrite;
	wire [15:0] idx  = paddr[17:2];
	wire        fall = lp_ff & !low_speed_clock;
	wire [1:0]  req  = {pin_irq_request_ch1, pin_irq_request_ch0};
	wire [1:0]  stm  = st_ff & msk_ff;
	wire [1:0]  w1c  = (wr && idx == tbcap_pkg::TBCAP_IDX_IRQ_ST) ? pwdata[1:0] : 2'h0;
	// shadow moves on the same edges as the design, so reads compare against $past
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{lp_ff, en_ff, arm_ff, flg_ff, cap_ff, st_ff, msk_ff} <= '0;
			d_ff <= '0;
		end else begin
			lp_ff <= low_speed_clock;
			cap_ff <= arm_ff & en_ff & {2{fall}};
			st_ff <= (st_ff & ~w1c) | cap_ff;
			if (wr && idx == tbcap_pkg::TBCAP_IDX_CONTROL)
				en_ff <= pwdata[1:0];
			if (wr && idx == tbcap_pkg::TBCAP_IDX_IRQ_MSK)
				msk_ff <= pwdata[1:0];
			for (int i = 0; i < 2; i++) begin
				arm_ff[i] <= en_ff[i] & (arm_ff[i] ? !fall : req[i] & !flg_ff[i]);
				if (arm_ff[i] && en_ff[i] && fall) begin
					flg_ff[i] <= 1'b1;
					d_ff[i] <= time_base_taps;
				end else if (wr && idx == tbcap_pkg::TBCAP_IDX_DATA0 + 16'(i))
					flg_ff[i] <= 1'b0;
			end
		end
	end
	sequence s_cap0;
		arm_ff[0] && en_ff[0] && fall && msk_ff[0];
	endsequence
	sequence s_cap1;
		arm_ff[1] && en_ff[1] && fall && msk_ff[1];
	endsequence
	AST_CTRL_READ: assert property (rd && idx == tbcap_pkg::TBCAP_IDX_CONTROL |-> prdata == 32'($past(en_ff)))
		else $error("control readback wrong");
	AST_FLAGS_READ: assert property (rd && idx == tbcap_pkg::TBCAP_IDX_FLAGS |-> prdata == 32'($past(flg_ff)))
		else $error("flags readback wrong");
	AST_DATA0_READ: assert property (rd && idx == tbcap_pkg::TBCAP_IDX_DATA0 |-> prdata == 32'($past(d_ff[0])))
		else $error("channel 0 data wrong");
	AST_DATA1_READ: assert property (rd && idx == tbcap_pkg::TBCAP_IDX_DATA1 |-> prdata == 32'($past(d_ff[1])))
		else $error("channel 1 data wrong");
	AST_CAP_IRQ0: assert property (s_cap0 |-> ##3 irq)
		else $error("no interrupt after channel 0 capture");
	AST_CAP_IRQ1: assert property (s_cap1 |-> ##3 irq)
		else $error("no interrupt after channel 1 capture");
	AST_IRQ_LEVEL: assert property (irq == |$past(stm))
		else $error("interrupt level wrong");
	AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data above byte not zero");
endmodule // tbcap_asserts

// ---- tbcap_chan.sv ----
// tbcap_chan: one capture channel, arm on pin request, latch taps on low-speed falling edge
// assumes: all inputs synchronous to pclk; ls_fall is a one-cycle pulse
`timescale 1ns/1ps
module tbcap_chan (
	// clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// control
	input  wire logic                 enable,
	input  wire logic                 trigger,
	input  wire logic                 ls_fall,
	input  wire logic [7:0]           taps,
	input  wire logic                 data_write,
	// result
	output tbcap_pkg::tbcap_chan_t    chan
);

	tbcap_pkg::tbcap_state_t state_ff;
	tbcap_pkg::tbcap_state_t nxt_state;
	logic [7:0]              data_ff;
	logic                    event_ff;
	logic                    take;

	// latch only from armed; a held flag blocks any new arm
	// enable gates the latch too, so a stop in the fall cycle leaves data and flag alone
	assign take = (state_ff == tbcap_pkg::TBCAP_ARMED) && enable && ls_fall;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			tbcap_pkg::TBCAP_IDLE: begin
				if (enable && trigger)
					nxt_state = tbcap_pkg::TBCAP_ARMED;
			end
			tbcap_pkg::TBCAP_ARMED: begin
				if (!enable)
					nxt_state = tbcap_pkg::TBCAP_IDLE;
				else if (ls_fall)
					nxt_state = tbcap_pkg::TBCAP_HELD;
			end
			tbcap_pkg::TBCAP_HELD: begin
				// triggers ignored here
				if (data_write)
					nxt_state = tbcap_pkg::TBCAP_IDLE;
			end
			default: nxt_state = tbcap_pkg::TBCAP_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_ff <= tbcap_pkg::TBCAP_IDLE;
		else
			state_ff <= nxt_state;
	end

	// bus writes never touch the data, only the capture does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			data_ff <= tbcap_pkg::TBCAP_RST_DATA;
		else if (take)
			data_ff <= taps;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			event_ff <= 1'b0;
		else
			event_ff <= take;
	end

	assign chan.data        = data_ff;
	assign chan.flag        = (state_ff == tbcap_pkg::TBCAP_HELD);
	assign chan.event_pulse = event_ff;

endmodule // tbcap_chan

// ---- tbcap_far.sv ----
// tbcap_far: pin request detector and low-speed time base in front of the capture unit
// assumes: one pclk domain; the low-speed clock is a divided pclk that runs free
`timescale 1ns/1ps
module tbcap_far #(
	parameter int HALF = 8
) (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// bench commands
	input wire logic [1:0] fire,
	// to the capture unit
	output logic           low_speed_clock,
	output logic [7:0]     time_base_taps,
	output logic           pin_irq_request_ch0,
	output logic           pin_irq_request_ch1
);
	int div_ff;
	// taps move on the rising edge only, so they are settled at every fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 0;
			low_speed_clock <= 1'b0;
			time_base_taps <= 8'h00;
		end else if (div_ff == HALF - 1) begin
			div_ff <= 0;
			low_speed_clock <= !low_speed_clock;
			if (!low_speed_clock)
				time_base_taps <= time_base_taps + 8'h01;
		end else
			div_ff <= div_ff + 1;
	end
	// edge selection happens upstream; one-cycle request per command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			{pin_irq_request_ch1, pin_irq_request_ch0} <= 2'h0;
		else
			{pin_irq_request_ch1, pin_irq_request_ch0} <= fire;
	end
endmodule // tbcap_far

// ---- tbcap_pkg.sv ----
// tbcap_pkg: constants, types and register map of the two-channel time base capture unit
// assumes: apb with 32-bit data, one aligned word per register, byte address = index * 4
package tbcap_pkg;

	// widths
	localparam int unsigned TBCAP_AW   = 18;
	localparam int unsigned TBCAP_DW   = 32;
	localparam int unsigned TBCAP_RW   = 8;
	localparam int unsigned TBCAP_NCH  = 2;
	localparam int unsigned TBCAP_NREG = 6;

	// register indices, printed offsets kept as indices
	localparam logic [15:0] TBCAP_IDX_CONTROL = 16'hf090;
	localparam logic [15:0] TBCAP_IDX_FLAGS   = 16'hf091;
	localparam logic [15:0] TBCAP_IDX_DATA0   = 16'hf092;
	localparam logic [15:0] TBCAP_IDX_DATA1   = 16'hf093;
	localparam logic [15:0] TBCAP_IDX_IRQ_ST  = 16'hf094;
	localparam logic [15:0] TBCAP_IDX_IRQ_MSK = 16'hf095;

	// select vector positions
	localparam int unsigned TBCAP_SEL_CONTROL = 0;
	localparam int unsigned TBCAP_SEL_FLAGS   = 1;
	localparam int unsigned TBCAP_SEL_DATA0   = 2;
	localparam int unsigned TBCAP_SEL_DATA1   = 3;
	localparam int unsigned TBCAP_SEL_IRQ_ST  = 4;
	localparam int unsigned TBCAP_SEL_IRQ_MSK = 5;

	// field positions: channel n enable / flag / event is bit n
	localparam int unsigned TBCAP_BIT_CH0 = 0;
	localparam int unsigned TBCAP_BIT_CH1 = 1;

	// reset values
	localparam logic [7:0] TBCAP_RST_CONTROL = 8'h00;
	localparam logic [7:0] TBCAP_RST_DATA    = 8'h00;
	localparam logic [7:0] TBCAP_RST_IRQ_MSK = 8'h00;
	localparam logic [1:0] TBCAP_RST_IRQ_ST  = 2'h0;

	// tap frequencies, bit 0 highest
	localparam int unsigned TBCAP_TAP_HI_HZ = 4096;
	localparam int unsigned TBCAP_TAP_LO_HZ = 32;

	// apb answer timing: pready comes this many cycles after the access phase starts
	localparam int unsigned TBCAP_WAIT_CYCLES = 1;

	typedef enum logic [2:0] {
		TBCAP_IDLE  = 3'h1,
		TBCAP_ARMED = 3'h2,
		TBCAP_HELD  = 3'h4
	} tbcap_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic       flag;
		logic       event_pulse;
	} tbcap_chan_t;

endpackage

// ---- tbcap_tb.sv ----
// testbench: apb-driven checks of the capture unit with its far-side model
// assumes: tbcap_pkg, tbcap_top, tbcap_far and tbcap_asserts compiled before
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module testbench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0;
	logic [1:0]  fire = 2'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, low_speed_clock, pin_irq_request_ch0, pin_irq_request_ch1;
	logic [7:0]  time_base_taps, e0, e1, x;
	int          errors = 0;
	int          compares = 0;
	always #2.5 pclk = !pclk;
	tbcap_top u_tbcap_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .low_speed_clock, .time_base_taps, .pin_irq_request_ch0, .pin_irq_request_ch1, .irq);
	tbcap_far u_tbcap_far (.pclk, .presetn, .fire, .low_speed_clock, .time_base_taps,
		.pin_irq_request_ch0, .pin_irq_request_ch1);
	task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] wd, output logic [31:0] r,
		output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= 32'(wd);
		@(posedge pclk);
		penable <= 1'b1;
		// no wait count assumed; only the watchdog ends a hang
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [15:0] i, input logic [7:0] ex, input logic eerr = 1'b0);
		logic [31:0] r;
		logic        err;
		apb(1'b0, i, 8'h00, r, err);
		`CHK(r, 32'(ex))
		`CHK(err, eerr)
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] d);
		logic [31:0] r;
		logic        err;
		apb(1'b1, i, d, r, err);
	endtask
	// request just after a low-speed rise, expected taps taken at the following fall
	task automatic trig(input int ch, output logic [7:0] e);
		@(posedge low_speed_clock);
		@(posedge pclk);
		fire <= 2'(1 << ch);
		@(posedge pclk);
		fire <= 2'h0;
		@(negedge low_speed_clock);
		e = time_base_taps;
		repeat (4) @(posedge pclk);
		#1;
	endtask
	task test_done;
		if (errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		test_done;
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rchk(tbcap_pkg::TBCAP_IDX_CONTROL + 16'(i), 8'h00);
		rchk(16'hf096, 8'h00, 1'b1);
		trig(0, x);
		rchk(tbcap_pkg::TBCAP_IDX_FLAGS, 8'h00);
		wr(tbcap_pkg::TBCAP_IDX_CONTROL, 8'hff);
		rchk(tbcap_pkg::TBCAP_IDX_CONTROL, 8'h03);
		wr(tbcap_pkg::TBCAP_IDX_IRQ_MSK, 8'h02);
		trig(0, e0);
		`CHK(irq, 1'b0)
		trig(1, e1);
		`CHK(irq, 1'b1)
		trig(0, x);
		trig(1, x);
		wr(tbcap_pkg::TBCAP_IDX_FLAGS, 8'h00);
		rchk(tbcap_pkg::TBCAP_IDX_FLAGS, 8'h03);
		rchk(tbcap_pkg::TBCAP_IDX_DATA0, e0);
		rchk(tbcap_pkg::TBCAP_IDX_DATA1, e1);
		wr(tbcap_pkg::TBCAP_IDX_DATA0, 8'hff);
		rchk(tbcap_pkg::TBCAP_IDX_FLAGS, 8'h02);
		rchk(tbcap_pkg::TBCAP_IDX_DATA0, e0);
		wr(tbcap_pkg::TBCAP_IDX_DATA1, 8'h5a);
		rchk(tbcap_pkg::TBCAP_IDX_FLAGS, 8'h00);
		rchk(tbcap_pkg::TBCAP_IDX_DATA1, e1);
		wr(tbcap_pkg::TBCAP_IDX_IRQ_ST, 8'h02);
		rchk(tbcap_pkg::TBCAP_IDX_IRQ_ST, 8'h01);
		`CHK(irq, 1'b0)
		wr(tbcap_pkg::TBCAP_IDX_IRQ_MSK, 8'h03);
		rchk(tbcap_pkg::TBCAP_IDX_IRQ_MSK, 8'h03);
		`CHK(irq, 1'b1)
		wr(tbcap_pkg::TBCAP_IDX_IRQ_ST, 8'h03);
		wr(tbcap_pkg::TBCAP_IDX_CONTROL, 8'h01);
		trig(0, e0);
		`CHK(irq, 1'b1)
		trig(1, x);
		rchk(tbcap_pkg::TBCAP_IDX_FLAGS, 8'h01);
		rchk(tbcap_pkg::TBCAP_IDX_DATA0, e0);
		test_done;
	end
endmodule // testbench
bind tbcap_top tbcap_asserts u_tbcap_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .prdata, .pslverr, .low_speed_clock, .time_base_taps, .pin_irq_request_ch0, .pin_irq_request_ch1, .irq);

// ---- tbcap_top.sv ----
// tbcap_top: two-channel time base capture unit with apb register slave and interrupt
// assumes: apb master synchronous to pclk; low-speed clock, taps and pin requests synchronous inputs
//
// Operation
// - channel captures only while its enable is set
// - enables are control bits 0, 1, reset zero
// - trigger is the pin interrupt request input
// - latch taps and set flag at low-speed fall
// - channel 0 loads only while its flag is 0
// - channel 1 loads only while its flag is 0
// - flags bit 0 shows channel 0 captured
// - flags bit 1 shows channel 1 captured
// - held flag ignores triggers, keeps data
// - writing data 0 clears flag 0 only
// - writing data 1 clears flag 1 only
// - data registers are 8 bits, reset zero
// - taps span 4096 Hz down to 32 Hz
`timescale 1ns/1ps
module tbcap_top (
	// clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [tbcap_pkg::TBCAP_AW-1:0] paddr,
	input  wire logic [tbcap_pkg::TBCAP_DW-1:0] pwdata,
	output logic                               pready,
	output logic [tbcap_pkg::TBCAP_DW-1:0]      prdata,
	output logic                               pslverr,
	// time base
	input  wire logic                          low_speed_clock,
	input  wire logic [7:0]                    time_base_taps,
	// pin interrupt requests
	input  wire logic                          pin_irq_request_ch0,
	input  wire logic                          pin_irq_request_ch1,
	// interrupt
	output logic                               irq
);

	localparam int unsigned NCH = tbcap_pkg::TBCAP_NCH;
	localparam int unsigned NR  = tbcap_pkg::TBCAP_NREG;

	// one-hot register select; used for both reads and writes
	function automatic logic [NR-1:0] reg_select(input logic [tbcap_pkg::TBCAP_AW-1:0] a);
		logic [NR-1:0] s;
		s = '0;
		s[tbcap_pkg::TBCAP_SEL_CONTROL] = (a == {tbcap_pkg::TBCAP_IDX_CONTROL, 2'h0});
		s[tbcap_pkg::TBCAP_SEL_FLAGS]   = (a == {tbcap_pkg::TBCAP_IDX_FLAGS, 2'h0});
		s[tbcap_pkg::TBCAP_SEL_DATA0]   = (a == {tbcap_pkg::TBCAP_IDX_DATA0, 2'h0});
		s[tbcap_pkg::TBCAP_SEL_DATA1]   = (a == {tbcap_pkg::TBCAP_IDX_DATA1, 2'h0});
		s[tbcap_pkg::TBCAP_SEL_IRQ_ST]  = (a == {tbcap_pkg::TBCAP_IDX_IRQ_ST, 2'h0});
		s[tbcap_pkg::TBCAP_SEL_IRQ_MSK] = (a == {tbcap_pkg::TBCAP_IDX_IRQ_MSK, 2'h0});
		return s;
	endfunction

	// apb handshake
	logic                          pready_ff;
	logic                          pslverr_ff;
	logic [tbcap_pkg::TBCAP_DW-1:0] prdata_ff;
	logic                          nxt_pready;
	logic                          access;
	logic                          commit;
	logic                          wr_commit;
	logic [NR-1:0]                 sel;
	logic                          mapped;

	// registers
	logic [7:0]                    control_ff;
	logic [7:0]                    irq_mask_ff;
	logic [NCH-1:0]                irq_status_ff;
	logic                          irq_ff;

	// low-speed edge detect
	logic                          ls_prev_ff;
	logic                          ls_fall;

	// channel wiring
	tbcap_pkg::tbcap_chan_t        chan     [NCH];
	logic [NCH-1:0]                trig;
	logic [NCH-1:0]                data_wr;
	logic [NCH-1:0]                cap_flags;
	logic [NCH-1:0]                cap_events;
	logic [NCH-1:0]                enables;

	assign sel    = reg_select(paddr);
	assign mapped = |sel;
	assign access = psel && penable;
	// one wait state keeps prdata a clean register output
	assign nxt_pready = access && !pready_ff;
	assign commit     = access && pready_ff;
	assign wr_commit  = commit && pwrite && mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready_ff <= 1'b0;
		else
			pready_ff <= nxt_pready;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pslverr_ff <= 1'b0;
		else
			pslverr_ff <= nxt_pready && !mapped;
	end

	// read data, low byte only; upper bits read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= '0;
		end else if (nxt_pready && !pwrite) begin
			prdata_ff <= '0;
			case (1'b1)
				sel[tbcap_pkg::TBCAP_SEL_CONTROL]: prdata_ff[7:0] <= control_ff;
				sel[tbcap_pkg::TBCAP_SEL_FLAGS]:   prdata_ff[NCH-1:0] <= cap_flags;
				sel[tbcap_pkg::TBCAP_SEL_DATA0]:   prdata_ff[7:0] <= chan[0].data;
				sel[tbcap_pkg::TBCAP_SEL_DATA1]:   prdata_ff[7:0] <= chan[1].data;
				sel[tbcap_pkg::TBCAP_SEL_IRQ_ST]:  prdata_ff[NCH-1:0] <= irq_status_ff;
				sel[tbcap_pkg::TBCAP_SEL_IRQ_MSK]: prdata_ff[7:0] <= irq_mask_ff;
				default:                           prdata_ff <= '0;
			endcase
		end else if (!access) begin
			prdata_ff <= '0;
		end
	end

	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata  = prdata_ff;

	// control register; only the enable bits are kept, the rest read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			control_ff <= tbcap_pkg::TBCAP_RST_CONTROL;
		else if (wr_commit && sel[tbcap_pkg::TBCAP_SEL_CONTROL])
			control_ff <= {6'h00, pwdata[1:0]};
	end

	assign enables[0] = control_ff[tbcap_pkg::TBCAP_BIT_CH0];
	assign enables[1] = control_ff[tbcap_pkg::TBCAP_BIT_CH1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_mask_ff <= tbcap_pkg::TBCAP_RST_IRQ_MSK;
		else if (wr_commit && sel[tbcap_pkg::TBCAP_SEL_IRQ_MSK])
			irq_mask_ff <= {6'h00, pwdata[1:0]};
	end

	// low-speed clock sampled as a plain input; capture acts on its falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ls_prev_ff <= 1'b0;
		else
			ls_prev_ff <= low_speed_clock;
	end

	assign ls_fall = ls_prev_ff && !low_speed_clock;

	assign trig[0] = pin_irq_request_ch0;
	assign trig[1] = pin_irq_request_ch1;

	// data writes clear the flag; written value is dropped
	assign data_wr[0] = wr_commit && sel[tbcap_pkg::TBCAP_SEL_DATA0];
	assign data_wr[1] = wr_commit && sel[tbcap_pkg::TBCAP_SEL_DATA1];

	generate
		for (genvar g = 0; g < NCH; g++) begin : g_chan
			tbcap_chan u_chan (
				.pclk       (pclk),
				.presetn    (presetn),
				.enable     (enables[g]),
				.trigger    (trig[g]),
				.ls_fall    (ls_fall),
				.taps       (time_base_taps),
				.data_write (data_wr[g]),
				.chan       (chan[g])
			);
			assign cap_flags[g]  = chan[g].flag;
			assign cap_events[g] = chan[g].event_pulse;
		end
	endgenerate

	// sticky event bits, write one to clear; a new event in the clear cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_status_ff <= tbcap_pkg::TBCAP_RST_IRQ_ST;
		else if (wr_commit && sel[tbcap_pkg::TBCAP_SEL_IRQ_ST])
			irq_status_ff <= (irq_status_ff & ~pwdata[NCH-1:0]) | cap_events;
		else
			irq_status_ff <= irq_status_ff | cap_events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(irq_status_ff & irq_mask_ff[NCH-1:0]);
	end

	assign irq = irq_ff;

endmodule // tbcap_top
